// ### bio_cpu_model.sv
/* processor core model: classic single Wishbone cycles.
   assumes a registered ack from the decoder and one clock. */
`default_nettype none
module bio_cpu_model (
  input wire logic clk_in,
  input wire logic ack_in,
  input wire logic [7:0] dat_in,
  output logic cyc_out = 1'b0,
  output logic stb_out = 1'b0,
  output logic we_out = 1'b0,
  output logic [7:0] adr_out = 8'h00,
  output logic [0:0] sel_out = 1'b0,
  output logic [7:0] dat_out = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  int n_to = 0;
  // one transfer, held until ack is sampled, released at that edge
  task automatic xfer(input logic we, input logic [7:0] adr,
    input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk_in);
    cyc_out <= 1'b1;
    stb_out <= 1'b1;
    we_out <= we;
    adr_out <= adr;
    sel_out <= 1'b1;
    dat_out <= wd;
    do begin
      @(posedge clk_in);
      n++;
    end while (!ack_in && n < 50);
    rd = dat_in;
    if (!ack_in) n_to++;
    cyc_out <= 1'b0;
    stb_out <= 1'b0;
    dat_out <= ~wd; // stale data never left on the bus
  endtask
endmodule // bio_cpu_model
`default_nettype wire

// ### bio_decode.v
/*
 * Banked register decoder: 512 bytes of byte-wide I/O space in two banks,
 * reached over a classic Wishbone slave with 8-bit data.
 * Assumes one clock, the processor's flag register living here, and pins
 * that arrive asynchronously.
 */
`default_nettype none
`include "bio_defs.vh"

// Overview of operation
// - register space totals 512 bytes, reached as I/O space.
// - two banks: bank 0 user registers, bank 1 a second set.
// - every access except the flag and analog bytes (F7, 80, 84) picks its bank from the bank-select flag.
// - flag set selects bank 1; flag clear selects bank 0.
// - each register honours its access class: read, write, logical, clear.
// - external reset pin is active high, held low by a pull-down.
// - serial programming pins are driven, not floating, during reset.
// - bank 1 holds drive-mode and other setup registers.
module bio_decode #(
  parameter NPORT = 2,
  parameter MEM_DEPTH = 16,
  parameter MEM_AW = 4
) (
  input wire CLK_SYS_IN,
  input wire RST_IN,
  input wire WB_CYC_IN,
  input wire WB_STB_IN,
  input wire WB_WE_IN,
  input wire [7:0] WB_ADR_IN,
  input wire [0:0] WB_SEL_IN,
  input wire [7:0] WB_DAT_IN,
  output wire [7:0] WB_DAT_OUT,
  output wire WB_ACK_OUT,
  input wire EXT_RESET_PIN_IN,
  input wire [7:0] PORT0_PIN_IN,
  input wire [7:0] PORT1_PIN_IN,
  output wire [7:0] PORT0_PIN_OUT,
  output wire [7:0] PORT0_PIN_OE_OUT,
  output wire [7:0] PORT1_PIN_OUT,
  output wire [7:0] PORT1_PIN_OE_OUT,
  input wire [3:0] TWOWIRE_EVENT_IN,
  input wire [3:0] TWOWIRE_MASTER_STAT_IN,
  output wire [3:0] TWOWIRE_CTRL_OUT,
  output wire [3:0] TWOWIRE_MCTRL_OUT,
  output wire BANK_SELECT_OUT
);

  // decode classes
  localparam [3:0] C_NONE = 4'd0;
  localparam [3:0] C_FLAGS = 4'd1;
  localparam [3:0] C_MEM = 4'd2;
  localparam [3:0] C_PDR = 4'd3;
  localparam [3:0] C_PIE = 4'd4;
  localparam [3:0] C_PGS = 4'd5;
  localparam [3:0] C_PDMH = 4'd6;
  localparam [3:0] C_PDM0 = 4'd7;
  localparam [3:0] C_PDM1 = 4'd8;
  localparam [3:0] C_TSCR = 4'd9;
  localparam [3:0] C_TMSCR = 4'd10;
  localparam NSYNC = 17;

  // bus handshake phase
  reg pend_q;
  reg ack_q;
  reg [7:0] dat_q;
  reg [7:0] dat_d;

  // processor flag register, bank select lives in it
  reg [7:0] flags_q;
  reg [3:0] tw_ctrl_q;
  reg [3:0] tw_stat_q;
  reg [3:0] tw_mctrl_q;

  // per-port registers, steer the pins
  reg [7:0] pdr_q [0:NPORT-1];
  reg [7:0] pie_q [0:NPORT-1];
  reg [7:0] pgs_q [0:NPORT-1];
  reg [7:0] pdmh_q [0:NPORT-1];
  reg [7:0] pdm0_q [0:NPORT-1];
  reg [7:0] pdm1_q [0:NPORT-1];
  reg [7:0] poe_q [0:NPORT-1];
  wire [7:0] pin_now [0:NPORT-1];

  // decode results
  reg [3:0] code;
  reg [MEM_AW-1:0] mem_idx;
  wire [7:0] adr_port;
  wire port_idx;
  wire bank;
  wire req;
  wire wr_now;
  wire ext_rst;
  wire [7:0] mem_rdata;

  // three-stage pin synchronisers
  reg [NSYNC-1:0] s1_q;
  reg [NSYNC-1:0] s2_q;
  reg [NSYNC-1:0] s3_q;
  reg [NSYNC-1:0] st_q;

  assign bank = flags_q[`BIO_FLAG_BANK_BIT];
  assign req = WB_CYC_IN & WB_STB_IN;
  assign wr_now = ack_q & req & WB_WE_IN & WB_SEL_IN[0]; // lands at ack edge
  assign adr_port = WB_ADR_IN & `BIO_PORT_MASK;
  assign port_idx = WB_ADR_IN[`BIO_PORT_BIT];
  assign ext_rst = st_q[NSYNC-1];
  assign pin_now[0] = st_q[7:0];
  assign pin_now[1] = st_q[15:8];

  // synchronise pins; a change counts once stages two and three agree
  genvar gs;
  generate
    for (gs = 0; gs < NSYNC; gs = gs + 1) begin : g_sync
      always @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
          s1_q[gs] <= 1'b0;
          s2_q[gs] <= 1'b0;
          s3_q[gs] <= 1'b0;
          st_q[gs] <= 1'b0;
        end else begin
          s1_q[gs] <= (gs == NSYNC - 1) ? EXT_RESET_PIN_IN :
                      (gs >= 8) ? PORT1_PIN_IN[gs % 8] :
                      PORT0_PIN_IN[gs % 8];
          s2_q[gs] <= s1_q[gs];
          s3_q[gs] <= s2_q[gs];
          if (s2_q[gs] == s3_q[gs]) begin
            st_q[gs] <= s3_q[gs];
          end
        end
      end
    end
  endgenerate

  // address decode: offset plus bank flag gives one of 512 bytes
  always @* begin
    code = C_NONE;
    mem_idx = {MEM_AW{1'b0}};
    if (WB_ADR_IN == `BIO_ADR_FLAGS) begin
      code = C_FLAGS;
    end else if (WB_ADR_IN == `BIO_ADR_ANALOG_A) begin
      code = C_MEM;
      mem_idx = `BIO_MIX_ANALOG_A;
    end else if (WB_ADR_IN == `BIO_ADR_ANALOG_B) begin
      code = C_MEM;
      mem_idx = `BIO_MIX_ANALOG_B;
    end else if (bank == `BIO_BANK_USER) begin
      if (WB_ADR_IN[7:3] != 5'h00) begin
        if (WB_ADR_IN == `BIO_ADR_TW_CFG) begin
          code = C_MEM;
          mem_idx = `BIO_MIX_TW_CFG;
        end else if (WB_ADR_IN == `BIO_ADR_TW_SCR) begin
          code = C_TSCR;
        end else if (WB_ADR_IN == `BIO_ADR_TW_DATA) begin
          code = C_MEM;
          mem_idx = `BIO_MIX_TW_DATA;
        end else if (WB_ADR_IN == `BIO_ADR_TW_MSCR) begin
          code = C_TMSCR;
        end else if (WB_ADR_IN == `BIO_ADR_IRQ_CLR0) begin
          code = C_MEM;
          mem_idx = `BIO_MIX_IRQ_CLR0;
        end else if (WB_ADR_IN == `BIO_ADR_IRQ_CLR1) begin
          code = C_MEM;
          mem_idx = `BIO_MIX_IRQ_CLR1;
        end else if (WB_ADR_IN == `BIO_ADR_IRQ_CLR3) begin
          code = C_MEM;
          mem_idx = `BIO_MIX_IRQ_CLR3;
        end
      end else if (adr_port == `BIO_ADR_PORT_DATA) begin
        code = C_PDR;
      end else if (adr_port == `BIO_ADR_PORT_IRQ_EN) begin
        code = C_PIE;
      end else if (adr_port == `BIO_ADR_PORT_GSEL) begin
        code = C_PGS;
      end else if (adr_port == `BIO_ADR_PORT_DM_HI) begin
        code = C_PDMH;
      end
    end else if (WB_ADR_IN[7:3] == 5'h00) begin
      if (adr_port == `BIO_ADR_PORT_DM0) begin
        code = C_PDM0;
      end else if (adr_port == `BIO_ADR_PORT_DM1) begin
        code = C_PDM1;
      end else begin
        code = C_MEM;
        mem_idx = `BIO_MIX_ICFG_BASE + {2'b00, port_idx, WB_ADR_IN[0]};
      end
    end
  end

  // config, interrupt-clear and analog bytes live in the memory
  bio_regmem #(
    .WIDTH(8),
    .DEPTH(MEM_DEPTH),
    .AW(MEM_AW)
  ) u_mem (
    .clk_in(CLK_SYS_IN),
    .rst_in(RST_IN),
    .clr_in(ext_rst),
    .we_in(wr_now && (code == C_MEM)),
    .waddr_in(mem_idx),
    .wdata_in(WB_DAT_IN),
    .raddr_in(mem_idx),
    .rdata_out(mem_rdata)
  );

  // read data by class; reserved holes read as zero
  always @* begin
    dat_d = `BIO_RST_BYTE;
    if (code == C_FLAGS) begin
      dat_d = flags_q;
    end else if (code == C_MEM) begin
      dat_d = mem_rdata;
    end else if (code == C_PDR) begin
      dat_d = pin_now[port_idx];
    end else if (code == C_PIE) begin
      dat_d = pie_q[port_idx];
    end else if (code == C_PGS) begin
      dat_d = pgs_q[port_idx];
    end else if (code == C_PDMH) begin
      dat_d = pdmh_q[port_idx];
    end else if (code == C_PDM0) begin
      dat_d = pdm0_q[port_idx];
    end else if (code == C_PDM1) begin
      dat_d = pdm1_q[port_idx];
    end else if (code == C_TSCR) begin
      dat_d = {tw_stat_q, tw_ctrl_q};
    end else if (code == C_TMSCR) begin
      dat_d = {TWOWIRE_MASTER_STAT_IN, tw_mctrl_q};
    end
  end

  // wishbone handshake: decode, then answer one cycle later
  always @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pend_q <= 1'b0;
      ack_q <= 1'b0;
      dat_q <= `BIO_RST_BYTE;
    end else begin
      pend_q <= req & ~pend_q & ~ack_q & ~ext_rst;
      ack_q <= pend_q & req;
      if (pend_q && !WB_WE_IN) begin
        dat_q <= dat_d;
      end
    end
  end

  // flag and two-wire status registers
  always @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      flags_q <= `BIO_RST_BYTE;
      tw_ctrl_q <= `BIO_RST_NIBBLE;
      tw_stat_q <= `BIO_RST_NIBBLE;
      tw_mctrl_q <= `BIO_RST_NIBBLE;
    end else if (ext_rst) begin
      flags_q <= `BIO_RST_BYTE;
      tw_ctrl_q <= `BIO_RST_NIBBLE;
      tw_stat_q <= `BIO_RST_NIBBLE;
      tw_mctrl_q <= `BIO_RST_NIBBLE;
    end else begin
      if (wr_now && (code == C_FLAGS)) begin
        flags_q <= WB_DAT_IN;
      end
      if (wr_now && (code == C_TSCR)) begin
        tw_ctrl_q <= WB_DAT_IN[`BIO_CTRL_MSB:0];
        // writing zero clears a status bit; a new event wins
        tw_stat_q <= (tw_stat_q &
          WB_DAT_IN[`BIO_STAT_MSB:`BIO_STAT_LSB]) | TWOWIRE_EVENT_IN;
      end else begin
        tw_stat_q <= tw_stat_q | TWOWIRE_EVENT_IN;
      end
      if (wr_now && (code == C_TMSCR)) begin
        tw_mctrl_q <= WB_DAT_IN[`BIO_CTRL_MSB:0];
      end
    end
  end

  // per-port registers and pin drive
  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp = gp + 1) begin : g_port
      wire hit = wr_now && (port_idx == gp);
      always @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
          pdr_q[gp] <= `BIO_RST_BYTE;
          pie_q[gp] <= `BIO_RST_BYTE;
          pgs_q[gp] <= `BIO_RST_BYTE;
          pdmh_q[gp] <= `BIO_RST_BYTE;
          pdm0_q[gp] <= `BIO_RST_BYTE;
          pdm1_q[gp] <= `BIO_RST_BYTE;
          poe_q[gp] <= (gp == 1) ? `BIO_PROG_PIN_MASK : `BIO_RST_BYTE;
        end else if (ext_rst) begin
          pdr_q[gp] <= `BIO_RST_BYTE;
          pie_q[gp] <= `BIO_RST_BYTE;
          pgs_q[gp] <= `BIO_RST_BYTE;
          pdmh_q[gp] <= `BIO_RST_BYTE;
          pdm0_q[gp] <= `BIO_RST_BYTE;
          pdm1_q[gp] <= `BIO_RST_BYTE;
          poe_q[gp] <= (gp == 1) ? `BIO_PROG_PIN_MASK : `BIO_RST_BYTE;
        end else begin
          if (hit && (code == C_PDR)) begin
            pdr_q[gp] <= WB_DAT_IN;
          end
          if (hit && (code == C_PIE)) begin
            pie_q[gp] <= WB_DAT_IN;
          end
          if (hit && (code == C_PGS)) begin
            pgs_q[gp] <= WB_DAT_IN;
          end
          if (hit && (code == C_PDMH)) begin
            pdmh_q[gp] <= WB_DAT_IN;
          end
          if (hit && (code == C_PDM0)) begin
            pdm0_q[gp] <= WB_DAT_IN;
          end
          if (hit && (code == C_PDM1)) begin
            pdm1_q[gp] <= WB_DAT_IN;
          end
          // drive where mode 0 is set and the high mode bit is clear
          poe_q[gp] <= pdm0_q[gp] & ~pdmh_q[gp];
        end
      end
    end
  endgenerate

  // outputs straight from flip-flops
  assign WB_DAT_OUT = dat_q;
  assign WB_ACK_OUT = ack_q;
  assign PORT0_PIN_OUT = pdr_q[0];
  assign PORT1_PIN_OUT = pdr_q[1];
  assign PORT0_PIN_OE_OUT = poe_q[0];
  assign PORT1_PIN_OE_OUT = poe_q[1];
  assign TWOWIRE_CTRL_OUT = tw_ctrl_q;
  assign TWOWIRE_MCTRL_OUT = tw_mctrl_q;
  assign BANK_SELECT_OUT = flags_q[`BIO_FLAG_BANK_BIT];

endmodule // bio_decode

`default_nettype wire

// ### bio_decode_checker.sv
/* checker: bus timing, bank routing, reserved holes, reset states.
   assumes a bind onto bio_decode and one clock domain. */
`default_nettype none
module bio_decode_checker (
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [0:0] WB_SEL_IN,
  input wire logic [7:0] WB_DAT_IN,
  input wire logic [7:0] WB_DAT_OUT,
  input wire logic WB_ACK_OUT,
  input wire logic EXT_RESET_PIN_IN,
  input wire logic [7:0] PORT0_PIN_OUT,
  input wire logic [7:0] PORT1_PIN_OE_OUT,
  input wire logic [3:0] TWOWIRE_CTRL_OUT,
  input wire logic BANK_SELECT_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (RST_IN);
  // accepted write with its byte lane on
  logic wr_ack;
  assign wr_ack = WB_ACK_OUT && WB_WE_IN && WB_SEL_IN[0];

  ack_pulse_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack longer than one cycle");
  ack_timing_a: assert property (
    $rose(WB_CYC_IN && WB_STB_IN) && !EXT_RESET_PIN_IN |->
    ##2 WB_ACK_OUT)
    else $error("ack not two edges after request");
  ack_cause_a: assert property (
    WB_ACK_OUT |-> $past(WB_CYC_IN && WB_STB_IN, 2))
    else $error("ack without request");
  bank_flag_a: assert property (
    wr_ack && WB_ADR_IN == 8'hF7 |=>
    BANK_SELECT_OUT == $past(WB_DAT_IN[4]))
    else $error("bank flag not written");
  tw_ctrl_a: assert property (
    wr_ack && WB_ADR_IN == 8'hD7 && !BANK_SELECT_OUT |=>
    TWOWIRE_CTRL_OUT == $past(WB_DAT_IN[3:0]))
    else $error("control nibble not written");
  hole_write_a: assert property (
    wr_ack && WB_ADR_IN == 8'hD7 && BANK_SELECT_OUT |=>
    $stable(TWOWIRE_CTRL_OUT))
    else $error("bank 1 write reached bank 0");
  hole_read_a: assert property (
    WB_ACK_OUT && !WB_WE_IN && WB_ADR_IN == 8'h10 |->
    WB_DAT_OUT == 8'h00)
    else $error("reserved read not zero");
  port_out_a: assert property (
    wr_ack && WB_ADR_IN == 8'h00 && !BANK_SELECT_OUT |=>
    PORT0_PIN_OUT == $past(WB_DAT_IN))
    else $error("port data not driven");
  prog_pin_a: assert property (
    disable iff (1'b0) $fell(RST_IN) |-> PORT1_PIN_OE_OUT == 8'h03)
    else $error("programming pins not driven");
  ext_reset_a: assert property (
    EXT_RESET_PIN_IN [*6] |-> !WB_ACK_OUT && BANK_SELECT_OUT == 1'b0)
    else $error("external reset not applied");
  cover property (wr_ack && WB_ADR_IN == 8'hF7 && WB_DAT_IN[4]);
  cover property (WB_ACK_OUT && !WB_WE_IN && WB_ADR_IN == 8'h10);
  cover property (EXT_RESET_PIN_IN [*6]);
endmodule // bio_decode_checker

bind bio_decode bio_decode_checker u_chk (.CLK_SYS_IN, .RST_IN,
  .WB_CYC_IN, .WB_STB_IN, .WB_WE_IN, .WB_ADR_IN, .WB_SEL_IN, .WB_DAT_IN,
  .WB_DAT_OUT, .WB_ACK_OUT, .EXT_RESET_PIN_IN, .PORT0_PIN_OUT,
  .PORT1_PIN_OE_OUT, .TWOWIRE_CTRL_OUT, .BANK_SELECT_OUT);
`default_nettype wire

// ### bio_defs.vh
/*
 * Shared constants of the banked register decoder: byte offsets inside a
 * bank, bank codes, field positions, reset values and storage indexes.
 * Assumes it is included by bare name before any module that uses it.
 */
`ifndef BIO_DEFS_VH
`define BIO_DEFS_VH

// bank codes and size of one bank
`define BIO_BANK_USER 1'b0
`define BIO_BANK_CONFIG 1'b1
`define BIO_BANK_BYTES 10'h0100

// offsets seen in both banks
`define BIO_ADR_FLAGS 8'hF7
`define BIO_ADR_ANALOG_A 8'h80
`define BIO_ADR_ANALOG_B 8'h84

// bank 0 offsets, port n sits at base plus four times n
`define BIO_ADR_PORT_DATA 8'h00
`define BIO_ADR_PORT_IRQ_EN 8'h01
`define BIO_ADR_PORT_GSEL 8'h02
`define BIO_ADR_PORT_DM_HI 8'h03
`define BIO_ADR_TW_CFG 8'hD6
`define BIO_ADR_TW_SCR 8'hD7
`define BIO_ADR_TW_DATA 8'hD8
`define BIO_ADR_TW_MSCR 8'hD9
`define BIO_ADR_IRQ_CLR0 8'hDA
`define BIO_ADR_IRQ_CLR1 8'hDB
`define BIO_ADR_IRQ_CLR3 8'hDD

// bank 1 offsets, port n sits at base plus four times n
`define BIO_ADR_PORT_DM0 8'h00
`define BIO_ADR_PORT_DM1 8'h01
`define BIO_ADR_PORT_ICFG0 8'h02
`define BIO_ADR_PORT_ICFG1 8'h03

// port stride and the address bit that picks the port
`define BIO_PORT_MASK 8'hFB
`define BIO_PORT_BIT 2

// flag register layout
`define BIO_FLAG_BANK_BIT 4

// split of the two mixed-access status registers
`define BIO_CTRL_MSB 3
`define BIO_STAT_LSB 4
`define BIO_STAT_MSB 7

// reset values
`define BIO_RST_BYTE 8'h00
`define BIO_RST_NIBBLE 4'h0
`define BIO_PROG_PIN_MASK 8'h03

// storage indexes inside the register memory
`define BIO_MIX_ANALOG_A 4'h0
`define BIO_MIX_ANALOG_B 4'h1
`define BIO_MIX_TW_CFG 4'h2
`define BIO_MIX_TW_DATA 4'h3
`define BIO_MIX_IRQ_CLR0 4'h4
`define BIO_MIX_IRQ_CLR1 4'h5
`define BIO_MIX_IRQ_CLR3 4'h6
`define BIO_MIX_ICFG_BASE 4'h7

`endif

// ### bio_regmem.v
/*
 * Small register memory: one write port, one read port whose data comes
 * out of a register one clock after the address.
 * Assumes a single clock and an asynchronous active-high reset.
 */
`default_nettype none

module bio_regmem #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_in,
  input wire rst_in,
  input wire clr_in,
  input wire we_in,
  input wire [AW-1:0] waddr_in,
  input wire [WIDTH-1:0] wdata_in,
  input wire [AW-1:0] raddr_in,
  output reg [WIDTH-1:0] rdata_out
);

  wire [WIDTH-1:0] word [0:DEPTH-1];

  // one storage word per entry, cleared by either reset
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_word
      localparam [AW-1:0] IDX = gi;
      reg [WIDTH-1:0] word_q;
      always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          word_q <= {WIDTH{1'b0}};
        end else if (clr_in) begin
          word_q <= {WIDTH{1'b0}};
        end else if (we_in && (waddr_in == IDX)) begin
          word_q <= wdata_in;
        end
      end
      assign word[gi] = word_q;
    end
  endgenerate

  // registered read port
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= {WIDTH{1'b0}};
    end else begin
      rdata_out <= word[raddr_in];
    end
  end

endmodule // bio_regmem

`default_nettype wire

// ### bio_regmem_unused_guard.v
/*
 * Intentionally empty helper file slot is not used.
 */
`default_nettype none
`default_nettype wire

// ### tb_banked_io_register_decode.sv
/* testbench: table of bank accesses, then pins, sticky bits, resets.
   assumes the decoder answers every request within fifty cycles. */
`default_nettype none
module tb_banked_io_register_decode;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic bank;
    logic we;
    logic [7:0] adr;
    logic [7:0] wd;
    logic [7:0] exp;
  } row_t;
  logic clk = 1'b0, rst = 1'b1, ext = 1'b0, cyc, stb, we, ack;
  logic [0:0] sel;
  logic [7:0] adr, wd, rdo, rd, oe0, oe1, p1o;
  logic [3:0] ev = 4'h0;
  int n_fail = 0, n_compared = 0;
  row_t rows [16] = '{
    '{1'b0, 1'b1, 8'h01, 8'hA5, 8'h00},
    '{1'b0, 1'b0, 8'h01, 8'h00, 8'hA5},
    '{1'b1, 1'b0, 8'h01, 8'h00, 8'h00},
    '{1'b1, 1'b1, 8'h01, 8'h3C, 8'h00},
    '{1'b1, 1'b0, 8'h01, 8'h00, 8'h3C},
    '{1'b0, 1'b0, 8'h01, 8'h00, 8'hA5},
    '{1'b0, 1'b1, 8'h80, 8'h77, 8'h00},
    '{1'b1, 1'b0, 8'h80, 8'h00, 8'h77},
    '{1'b0, 1'b1, 8'h10, 8'hFF, 8'h00},
    '{1'b0, 1'b0, 8'h10, 8'h00, 8'h00},
    '{1'b1, 1'b1, 8'hD6, 8'h11, 8'h00},
    '{1'b0, 1'b0, 8'hD6, 8'h00, 8'h00},
    '{1'b0, 1'b1, 8'hD9, 8'h0F, 8'h00},
    '{1'b0, 1'b0, 8'hD9, 8'h00, 8'h6F},
    '{1'b0, 1'b0, 8'h00, 8'h00, 8'h5A},
    '{1'b0, 1'b0, 8'h04, 8'h00, 8'hC3}};
  logic [3:0] tw_ctrl, mctrl;
  logic bank_out;

  // clock of 40 ns period
  always #20 clk = ~clk;

  bio_cpu_model u_cpu (.clk_in(clk), .ack_in(ack), .dat_in(rdo),
    .cyc_out(cyc), .stb_out(stb), .we_out(we), .adr_out(adr),
    .sel_out(sel), .dat_out(wd));
  bio_decode u_dut (.CLK_SYS_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
    .WB_DAT_IN(wd), .WB_DAT_OUT(rdo), .WB_ACK_OUT(ack),
    .EXT_RESET_PIN_IN(ext), .PORT0_PIN_IN(8'h5A), .PORT1_PIN_IN(8'hC3),
    .PORT0_PIN_OUT(), .PORT0_PIN_OE_OUT(oe0), .PORT1_PIN_OUT(p1o),
    .PORT1_PIN_OE_OUT(oe1), .TWOWIRE_EVENT_IN(ev),
    .TWOWIRE_MASTER_STAT_IN(4'h6), .TWOWIRE_CTRL_OUT(tw_ctrl),
    .TWOWIRE_MCTRL_OUT(mctrl), .BANK_SELECT_OUT(bank_out));

  task automatic chk(input string nm, input logic [7:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic final_report();
    n_fail = n_fail + u_cpu.n_to;
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    #(40 * 4000);
    n_fail++;
    final_report();
  end

  // main sequence
  initial begin
    do_reset();
    for (int i = 0; i < 16; i++) begin
      u_cpu.xfer(1'b1, 8'hF7, {3'h0, rows[i].bank, 4'h0}, rd);
      u_cpu.xfer(rows[i].we, rows[i].adr, rows[i].wd, rd);
      if (!rows[i].we) chk("table read", rows[i].exp, rd);
    end
    chk("mctrl out", 8'h0F, {4'h0, mctrl});
    // port 1 data register drives its pins
    u_cpu.xfer(1'b1, 8'h04, 8'h96, rd);
    @(posedge clk);
    chk("port1 data out", 8'h96, p1o);
    // drive mode 0 in bank 1, drive mode high in bank 0
    u_cpu.xfer(1'b1, 8'hF7, 8'h10, rd);
    u_cpu.xfer(1'b1, 8'h00, 8'hFF, rd);
    u_cpu.xfer(1'b1, 8'hF7, 8'h00, rd);
    u_cpu.xfer(1'b1, 8'h03, 8'h0F, rd);
    repeat (2) @(posedge clk);
    chk("port0 enables", 8'hF0, oe0);
    // sticky status: set by event, cleared by writing zero
    @(posedge clk) ev <= 4'h3;
    @(posedge clk) ev <= 4'h0;
    u_cpu.xfer(1'b1, 8'hD7, 8'hF5, rd);
    u_cpu.xfer(1'b0, 8'hD7, 8'h00, rd);
    chk("status set", 8'h35, rd);
    u_cpu.xfer(1'b1, 8'hD7, 8'h25, rd);
    u_cpu.xfer(1'b0, 8'hD7, 8'h00, rd);
    chk("status cleared", 8'h25, rd);
    chk("control out", 8'h05, {4'h0, tw_ctrl});
    // external reset pin clears bank flag and port 0 interrupt enable
    u_cpu.xfer(1'b1, 8'hF7, 8'h10, rd);
    @(posedge clk) ext <= 1'b1;
    repeat (8) @(posedge clk);
    ext <= 1'b0;
    repeat (6) @(posedge clk);
    chk("bank after pin", 8'h00, {7'h00, bank_out});
    u_cpu.xfer(1'b0, 8'h01, 8'h00, rd);
    chk("data after pin", 8'h00, rd);
    u_cpu.xfer(1'b1, 8'hF7, 8'h10, rd);
    do_reset();
    chk("prog pins in reset", 8'h03, oe1);
    repeat (2) @(posedge clk);
    chk("bank after reset", 8'h00, {7'h00, bank_out});
    chk("prog pins after reset", 8'h00, oe1);
    final_report();
  end
endmodule // tb_banked_io_register_decode
`default_nettype wire
